// ### hw/tbc_core.sv
// Functional notes
// - Mode 00 is one 16-bit up-counter
// - 16-bit match sets flag, clears, continues
// - Trigger select 00 counts continuously
// - Enable bit starts and stops timer
// - Clear bit restarts count, self-clears
// - Flag requests interrupt only when enabled
// - Mode 01 counts up then down
// - At period, turn down after delay
// - Down to zero sets flag, counts up
// - Mode 10 gives two 8-bit counters
// - Low byte match sets flag, clears low
// - High byte match gives event, clears high
// - Both bytes start on shared trigger
// - Clear resets both bytes together
// - Mode 11 cascades low into high
// - Low match sets flag, bumps high byte
// - High byte wraps 255 to zero
// - Selected source divided by prescaler
// - Register access restarts the count only through the clear bit
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tbc_regs.svh"

module tbc_core (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_ext_clk,
  input  wire logic        i_start_trig,
  output logic             o_irq,
  output logic [15:0]      o_count_value
);

  tbc_pkg::tbc_core_st_t s_q;
  tbc_pkg::tbc_core_st_t s_d;
  logic                  presc_tick;
  logic                  src_tick;
  logic                  cnt_go;
  logic                  wr_fire;

  function automatic tbc_pkg::tbc_reg_t decode(input logic [11:0] addr);
    case (addr)
      `TBC_OFS_CTRL:   decode = tbc_pkg::TBC_REG_CTRL;
      `TBC_OFS_STAT:   decode = tbc_pkg::TBC_REG_STAT;
      `TBC_OFS_COUNT:  decode = tbc_pkg::TBC_REG_COUNT;
      `TBC_OFS_PERIOD: decode = tbc_pkg::TBC_REG_PERIOD;
      default:         decode = tbc_pkg::TBC_REG_NONE;
    endcase
  endfunction

  function automatic logic [31:0] rd_word(input tbc_pkg::tbc_reg_t sel,
                                          input tbc_pkg::tbc_core_st_t st);
    rd_word = 32'h0000_0000;
    case (sel)
      tbc_pkg::TBC_REG_CTRL: begin
        rd_word[`TBC_CTRL_EN]                         = st.en;
        rd_word[`TBC_CTRL_MODE_HI:`TBC_CTRL_MODE_LO] = st.mode;
        rd_word[`TBC_CTRL_TRIG_HI:`TBC_CTRL_TRIG_LO] = st.trig;
        rd_word[`TBC_CTRL_CLR]                        = st.clr;
        rd_word[`TBC_CTRL_IRQEN]                      = st.irq_en;
        rd_word[`TBC_CTRL_SRC]                        = st.src;
        rd_word[`TBC_CTRL_PSC_HI:`TBC_CTRL_PSC_LO]   = st.psc;
      end
      tbc_pkg::TBC_REG_STAT: begin
        rd_word[`TBC_STAT_OVF]  = st.ovf;
        rd_word[`TBC_STAT_HIEV] = st.hiev;
        rd_word[`TBC_STAT_DOWN] = st.dir_down;
        rd_word[`TBC_STAT_RUN]  = st.run;
      end
      tbc_pkg::TBC_REG_COUNT:  rd_word[15:0] = st.count;
      tbc_pkg::TBC_REG_PERIOD: rd_word[15:0] = st.period;
      default:                 rd_word = 32'h0000_0000;
    endcase
  endfunction

  // Internal source runs every cycle; pin source counts its filtered rising edges
  assign src_tick = s_q.src ? (s_q.ext_sync[2] == s_q.ext_sync[1]) &
                              s_q.ext_sync[1] & ~s_q.ext_lvl : 1'b1;

  tbc_presc u_presc (
    .i_sys_clk  (i_sys_clk),
    .i_rst_b    (i_rst_b),
    .i_src_tick (src_tick),
    .i_sel      (s_q.psc),
    .i_clr      (s_q.clr | ~s_q.en),
    .o_tick     (presc_tick)
  );

  assign cnt_go  = presc_tick & s_q.en & s_q.run & ~s_q.clr;
  assign wr_fire = i_psel & i_penable & s_q.pready & i_pwrite & ~s_q.pslverr;

  always_comb begin
    logic             trg_new;
    logic             trg_rise;
    logic             trg_fall;
    logic [7:0]       lo;
    logic [7:0]       hi;
    tbc_pkg::tbc_reg_t sel;
    trg_new  = s_q.trg_lvl;
    trg_rise = 1'b0;
    trg_fall = 1'b0;
    lo       = s_q.count[7:0];
    hi       = s_q.count[15:8];
    sel      = decode(i_paddr);
    s_d         = s_q;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.clr     = 1'b0;

    // Pin synchronisers; a level counts once stages two and three agree
    s_d.ext_sync = {s_q.ext_sync[1:0], i_ext_clk};
    s_d.trg_sync = {s_q.trg_sync[1:0], i_start_trig};
    if (s_q.ext_sync[2] == s_q.ext_sync[1]) begin
      s_d.ext_lvl = s_q.ext_sync[1];
    end
    if (s_q.trg_sync[2] == s_q.trg_sync[1]) begin
      trg_new = s_q.trg_sync[1];
    end
    s_d.trg_lvl = trg_new;
    trg_rise    = trg_new & ~s_q.trg_lvl;
    trg_fall    = ~trg_new & s_q.trg_lvl;

    // APB: answer one cycle into the access phase, write on the pready edge
    if (i_psel & i_penable & ~s_q.pready) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = (sel == tbc_pkg::TBC_REG_NONE);
      s_d.prdata  = rd_word(sel, s_q);
    end
    if (wr_fire) begin
      unique case (sel)
        tbc_pkg::TBC_REG_CTRL: begin
          s_d.en     = i_pwdata[`TBC_CTRL_EN];
          s_d.mode   = tbc_pkg::tbc_mode_t'(i_pwdata[`TBC_CTRL_MODE_HI:`TBC_CTRL_MODE_LO]);
          s_d.trig   = tbc_pkg::tbc_trig_t'(i_pwdata[`TBC_CTRL_TRIG_HI:`TBC_CTRL_TRIG_LO]);
          s_d.clr    = i_pwdata[`TBC_CTRL_CLR];
          s_d.irq_en = i_pwdata[`TBC_CTRL_IRQEN];
          s_d.src    = i_pwdata[`TBC_CTRL_SRC];
          s_d.psc    = i_pwdata[`TBC_CTRL_PSC_HI:`TBC_CTRL_PSC_LO];
        end
        tbc_pkg::TBC_REG_STAT: begin
          if (i_pwdata[`TBC_STAT_OVF]) begin
            s_d.ovf = 1'b0;
          end
          if (i_pwdata[`TBC_STAT_HIEV]) begin
            s_d.hiev = 1'b0;
          end
        end
        tbc_pkg::TBC_REG_PERIOD: s_d.period = i_pwdata[15:0];
        default: ;  // Count register is read-only; writes change nothing
      endcase
    end

    // Start control; both bytes share one run latch
    if (!s_q.en) begin
      s_d.run = 1'b0;
    end else if (s_q.trig == tbc_pkg::TBC_TRIG_ALWAYS) begin
      s_d.run = 1'b1;
    end else if ((s_q.trig == tbc_pkg::TBC_TRIG_RISE && trg_rise) ||
                 (s_q.trig == tbc_pkg::TBC_TRIG_FALL && trg_fall) ||
                 (s_q.trig == tbc_pkg::TBC_TRIG_EDGE && (trg_rise || trg_fall))) begin
      s_d.run = 1'b1;
    end

    if (s_q.mode != tbc_pkg::TBC_MODE_17) begin
      s_d.dir_down  = 1'b0;
      s_d.turn_pend = 1'b0;
    end else if (s_q.turn_pend) begin
      s_d.dir_down  = 1'b1;
      s_d.turn_pend = 1'b0;
    end

    // Counting; event sets come after software clears so a set wins
    if (s_q.clr) begin
      s_d.count     = 16'h0000;
      s_d.dir_down  = 1'b0;
      s_d.turn_pend = 1'b0;
    end else if (cnt_go) begin
      unique case (s_q.mode)
        tbc_pkg::TBC_MODE_16: begin
          if (s_q.count >= s_q.period) begin
            s_d.count = 16'h0000;
            s_d.ovf   = 1'b1;
          end else begin
            s_d.count = 16'(s_q.count + 16'h0001);
          end
        end
        tbc_pkg::TBC_MODE_17: begin
          if (!s_q.dir_down) begin
            if (s_q.count >= s_q.period) begin
              s_d.turn_pend = ~s_q.turn_pend;
            end else begin
              s_d.count = 16'(s_q.count + 16'h0001);
              if (16'(s_q.count + 16'h0001) >= s_q.period) begin
                s_d.turn_pend = 1'b1;
              end
            end
          end else if (s_q.count <= 16'h0001) begin
            s_d.count    = 16'h0000;
            s_d.ovf      = 1'b1;
            s_d.dir_down = 1'b0;
          end else begin
            s_d.count = 16'(s_q.count - 16'h0001);
          end
        end
        tbc_pkg::TBC_MODE_DUAL: begin
          if (lo >= s_q.period[7:0]) begin
            lo      = 8'h00;
            s_d.ovf = 1'b1;
          end else begin
            lo = 8'(lo + 8'h01);
          end
          if (hi >= s_q.period[15:8]) begin
            hi       = 8'h00;
            s_d.hiev = 1'b1;
          end else begin
            hi = 8'(hi + 8'h01);
          end
          s_d.count = {hi, lo};
        end
        tbc_pkg::TBC_MODE_CASC: begin
          if (lo >= s_q.period[7:0]) begin
            lo      = 8'h00;
            s_d.ovf = 1'b1;
            hi      = 8'(hi + 8'h01);
          end else begin
            lo = 8'(lo + 8'h01);
          end
          s_d.count = {hi, lo};
        end
      endcase
    end

    s_d.irq = s_d.ovf & s_d.irq_en;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q        <= '0;
      s_q.period <= `TBC_RST_PERIOD;
      s_q.count  <= `TBC_RST_COUNT;
      s_q.psc    <= `TBC_RST_PSC;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_prdata      = s_q.prdata;
  assign o_pready      = s_q.pready;
  assign o_pslverr     = s_q.pslverr;
  assign o_irq         = s_q.irq;
  assign o_count_value = s_q.count;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  AST_M16_WRAP: assert property (
    cnt_go && s_q.mode == tbc_pkg::TBC_MODE_16 && s_q.count == s_q.period
    |=> s_q.count == 16'h0000 && s_q.ovf)
    else $error("16-bit match did not clear count and set flag");

  AST_M16_INC: assert property (
    cnt_go && s_q.mode == tbc_pkg::TBC_MODE_16 && s_q.count < s_q.period
    |=> s_q.count == 16'($past(s_q.count) + 16'h0001))
    else $error("16-bit count did not step by one");

  AST_TRIG_ALWAYS: assert property (
    s_q.en && s_q.trig == tbc_pkg::TBC_TRIG_ALWAYS |=> s_q.run)
    else $error("continuous trigger did not run the counter");

  AST_HOLD_OFF: assert property (
    !s_q.en && !s_q.clr |=> s_q.count == $past(s_q.count) && !$rose(s_q.ovf))
    else $error("disabled counter moved or flagged");

  AST_CLR_SELF: assert property (
    s_q.clr |=> !s_q.clr && s_q.count == 16'h0000 && !s_q.dir_down)
    else $error("clear bit did not zero count or self-clear");

  AST_IRQ_GATE: assert property (
    o_irq == (s_q.ovf && s_q.irq_en))
    else $error("interrupt does not follow flag and enable");

  AST_M17_TURN: assert property (
    s_q.turn_pend && s_q.mode == tbc_pkg::TBC_MODE_17 && !s_q.clr
    |=> s_q.dir_down && s_q.count == $past(s_q.count))
    else $error("17-bit mode did not turn down after delay");

  AST_M17_ZERO: assert property (
    cnt_go && s_q.mode == tbc_pkg::TBC_MODE_17 && s_q.dir_down
    && s_q.count == 16'h0001
    |=> s_q.count == 16'h0000 && s_q.ovf && !s_q.dir_down)
    else $error("17-bit down count to zero not handled");

  AST_DUAL_HI: assert property (
    cnt_go && s_q.mode == tbc_pkg::TBC_MODE_DUAL
    && s_q.count[15:8] == s_q.period[15:8]
    |=> s_q.count[15:8] == 8'h00 && s_q.hiev)
    else $error("dual mode high byte match not handled");

  AST_CASC_LO: assert property (
    cnt_go && s_q.mode == tbc_pkg::TBC_MODE_CASC
    && s_q.count[7:0] == s_q.period[7:0]
    |=> s_q.count[7:0] == 8'h00 && s_q.ovf
    && s_q.count[15:8] == 8'($past(s_q.count[15:8]) + 8'h01))
    else $error("cascade low match did not bump high byte");

  AST_NO_RESTART: assert property (
    wr_fire && !cnt_go && !s_q.clr && decode(i_paddr) != tbc_pkg::TBC_REG_CTRL
    |=> s_q.count == $past(s_q.count))
    else $error("register write disturbed the count");

  AST_DUAL_LO: assert property (
    cnt_go && s_q.mode == tbc_pkg::TBC_MODE_DUAL
    && s_q.count[7:0] == s_q.period[7:0]
    |=> s_q.count[7:0] == 8'h00 && s_q.ovf)
    else $error("dual mode low byte match not handled");

  AST_M17_UP: assert property (
    cnt_go && s_q.mode == tbc_pkg::TBC_MODE_17 && !s_q.dir_down
    && s_q.count < s_q.period
    |=> s_q.count == 16'($past(s_q.count) + 16'h0001))
    else $error("17-bit up count did not step by one");

  AST_RUN_OFF: assert property (
    !s_q.en |=> !s_q.run)
    else $error("disabled timer kept its run latch");

  COV_M16_WRAP: cover property (
    cnt_go && s_q.mode == tbc_pkg::TBC_MODE_16 && s_q.count == s_q.period);
  COV_M17_TURN: cover property (s_q.turn_pend ##1 s_q.dir_down);
  COV_CASC_WRAP: cover property (
    cnt_go && s_q.mode == tbc_pkg::TBC_MODE_CASC && s_q.count[15:8] == 8'hFF
    && s_q.count[7:0] == s_q.period[7:0]);
  COV_IRQ: cover property ($rose(o_irq));

endmodule

`default_nettype wire

// ### hw/tbc_presc.sv
`timescale 1ns/1ps
`default_nettype none
`include "tbc_regs.svh"

// Divides the selected source tick by 1, 2, 4 or 8
module tbc_presc (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_src_tick,
  input  wire logic [1:0] i_sel,
  input  wire logic       i_clr,
  output logic            o_tick
);

  tbc_pkg::tbc_psc_st_t s_q;
  tbc_pkg::tbc_psc_st_t s_d;

  function automatic logic [2:0] div_last(input logic [1:0] sel);
    div_last = 3'((4'h1 << sel) - 4'h1);
  endfunction

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (i_clr) begin
      s_d.cnt = 3'h0;
    end else if (i_src_tick) begin
      if (s_q.cnt >= div_last(i_sel)) begin
        s_d.cnt  = 3'h0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = 3'(s_q.cnt + 3'h1);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;

endmodule

`default_nettype wire

// ### pkg/tbc_pkg.sv
package tbc_pkg;

  typedef enum logic [1:0] {
    TBC_MODE_16   = 2'h0,
    TBC_MODE_17   = 2'h1,
    TBC_MODE_DUAL = 2'h2,
    TBC_MODE_CASC = 2'h3
  } tbc_mode_t;

  typedef enum logic [1:0] {
    TBC_TRIG_ALWAYS = 2'h0,
    TBC_TRIG_RISE   = 2'h1,
    TBC_TRIG_FALL   = 2'h2,
    TBC_TRIG_EDGE   = 2'h3
  } tbc_trig_t;

  typedef enum logic [2:0] {
    TBC_REG_CTRL,
    TBC_REG_STAT,
    TBC_REG_COUNT,
    TBC_REG_PERIOD,
    TBC_REG_NONE
  } tbc_reg_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
  } tbc_psc_st_t;

  typedef struct packed {
    logic        en;
    tbc_mode_t   mode;
    tbc_trig_t   trig;
    logic        clr;
    logic        irq_en;
    logic        src;
    logic [1:0]  psc;
    logic [15:0] period;
    logic [15:0] count;
    logic        dir_down;
    logic        turn_pend;
    logic        run;
    logic        ovf;
    logic        hiev;
    logic        irq;
    logic [2:0]  ext_sync;
    logic        ext_lvl;
    logic [2:0]  trg_sync;
    logic        trg_lvl;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tbc_core_st_t;

endpackage

// ### pkg/tbc_regs.svh
`ifndef TBC_REGS_SVH
`define TBC_REGS_SVH

// Register byte offsets
`define TBC_OFS_CTRL      12'h000
`define TBC_OFS_STAT      12'h004
`define TBC_OFS_COUNT     12'h008
`define TBC_OFS_PERIOD    12'h00C

// Control register fields
`define TBC_CTRL_EN       0
`define TBC_CTRL_MODE_LO  1
`define TBC_CTRL_MODE_HI  2
`define TBC_CTRL_TRIG_LO  3
`define TBC_CTRL_TRIG_HI  4
`define TBC_CTRL_CLR      5
`define TBC_CTRL_IRQEN    6
`define TBC_CTRL_SRC      7
`define TBC_CTRL_PSC_LO   8
`define TBC_CTRL_PSC_HI   9

// Status register fields
`define TBC_STAT_OVF      0
`define TBC_STAT_HIEV     1
`define TBC_STAT_DOWN     2
`define TBC_STAT_RUN      3

// Reset values
`define TBC_RST_PERIOD    16'hFFFF
`define TBC_RST_COUNT     16'h0000
`define TBC_RST_PSC       2'h0

// Timing
`define TBC_PSC_CNT_W     3

`endif

// ### tb/tbc_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tbc_regs.svh"

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tbc_core_tb_top;
  logic        i_sys_clk;
  logic        i_rst_b;
  logic        i_psel;
  logic        i_penable;
  logic        i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata;
  logic        i_ext_clk;
  logic        i_start_trig;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        o_irq;
  logic [15:0] o_count_value;
  logic [31:0] rd;
  logic        er;
  logic [15:0] per;
  logic [15:0] c0;
  logic [15:0] d;
  int          num_errors;
  int          checks;
  int          seed;

  tbc_core dut (
    .i_sys_clk     (i_sys_clk),
    .i_rst_b       (i_rst_b),
    .i_psel        (i_psel),
    .i_penable     (i_penable),
    .i_pwrite      (i_pwrite),
    .i_paddr       (i_paddr),
    .i_pwdata      (i_pwdata),
    .o_prdata      (o_prdata),
    .o_pready      (o_pready),
    .o_pslverr     (o_pslverr),
    .i_ext_clk     (i_ext_clk),
    .i_start_trig  (i_start_trig),
    .o_irq         (o_irq),
    .o_count_value (o_count_value)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  task automatic wrap_up;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
    int n;
    @(posedge i_sys_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= dat;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    rd = o_prdata;
    er = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      wrap_up();
    end
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] t,
                                      input logic c, input logic ie, input logic s,
                                      input logic [1:0] p);
    return {22'h0, p, s, ie, c, t, m, 1'b1};
  endfunction

  // Expected count after one tick, compare by greater-or-equal
  function automatic logic [15:0] nxt(input logic [1:0] m, input logic [15:0] c,
                                      input logic [15:0] p);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = (c[7:0] >= p[7:0]) ? 8'h00 : c[7:0] + 8'h01;
    hi = (c[15:8] >= p[15:8]) ? 8'h00 : c[15:8] + 8'h01;
    case (m)
      2'h0: return (c >= p) ? 16'h0000 : c + 16'h0001;
      2'h2: return {hi, lo};
      default: return {(c[7:0] >= p[7:0]) ? c[15:8] + 8'h01 : c[15:8], lo};
    endcase
  endfunction

  task automatic track(input logic [1:0] m, input int n);
    logic [15:0] pv;
    int          k;
    cyc(2);
    k = 0;
    do begin
      @(posedge i_sys_clk);
      k++;
    end while (o_count_value === 16'h0000 && k < 10);
    `CHK(o_count_value !== 16'h0000, 1'b1)
    pv = o_count_value;
    repeat (n) begin
      @(posedge i_sys_clk);
      `CHK(o_count_value, nxt(m, pv, per))
      pv = o_count_value;
    end
  endtask

  initial begin
    logic [1:0]  m;
    logic [31:0] rnd;
    logic        sp;
    logic        sz;
    seed = 29856;
    num_errors = 0;
    checks = 0;
    i_rst_b = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
    i_ext_clk = 1'b0;
    i_start_trig = 1'b0;
    cyc(16);
    i_rst_b <= 1'b1;
    cyc(1);
    `CHK(o_count_value, 16'h0000)
    apb(1'b0, `TBC_OFS_PERIOD, 32'h0);
    `CHK(rd, 32'h0000FFFF)
    apb(1'b0, 12'h010, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 2'h0 : (i == 1) ? 2'h2 : 2'h3;
      rnd = $random(seed);
      if (m == 2'h0) per = {11'h0, rnd[4:0]} + 16'h0002;
      else if (m == 2'h2) per = {3'h0, rnd[12:8], 3'h0, rnd[4:0]} + 16'h0101;
      else per = {rnd[7:0], 8'h00};
      apb(1'b1, `TBC_OFS_PERIOD, {16'h0, per});
      apb(1'b1, `TBC_OFS_STAT, 32'h3);
      apb(1'b1, `TBC_OFS_CTRL, ctl(m, 2'h0, 1'b1, (m == 2'h0), 1'b0, 2'h0));
      track(m, 300);
      `CHK(o_irq, (m == 2'h0))
      apb(1'b1, `TBC_OFS_CTRL, 32'h0);
      apb(1'b0, `TBC_OFS_STAT, 32'h0);
      `CHK(rd[0], 1'b1)
      `CHK(rd[1], (m == 2'h2))
      c0 = o_count_value;
      cyc(20);
      `CHK(o_count_value, c0)
      apb(1'b1, `TBC_OFS_STAT, 32'h3);
      apb(1'b0, `TBC_OFS_STAT, 32'h0);
      `CHK({o_irq, rd[0]}, 2'b00)
    end
    per = 16'hFFFF;
    apb(1'b1, `TBC_OFS_PERIOD, 32'h0000FFFF);
    apb(1'b1, `TBC_OFS_CTRL, ctl(2'h2, 2'h0, 1'b1, 1'b0, 1'b0, 2'h0));
    cyc(40);
    `CHK(o_count_value[7:0], o_count_value[15:8])
    c0 = o_count_value;
    apb(1'b1, `TBC_OFS_COUNT, 32'h0);
    apb(1'b1, `TBC_OFS_PERIOD, 32'h0000FFFF);
    apb(1'b0, `TBC_OFS_CTRL, 32'h0);
    `CHK(o_count_value[7:0] > c0[7:0] + 8'h08, 1'b1)
    apb(1'b1, `TBC_OFS_CTRL, ctl(2'h2, 2'h0, 1'b1, 1'b0, 1'b0, 2'h0));
    apb(1'b0, `TBC_OFS_COUNT, 32'h0);
    `CHK(rd[15:0] < 16'h0707 && rd[7:0] == rd[15:8], 1'b1)
    apb(1'b0, `TBC_OFS_CTRL, 32'h0);
    `CHK(rd[5], 1'b0)
    // Stop first so the run latch drops; then rise, fall and either edge start it
    for (int t = 1; t < 4; t++) begin
      apb(1'b1, `TBC_OFS_CTRL, 32'h0);
      apb(1'b1, `TBC_OFS_CTRL, ctl(2'h0, 2'(t), 1'b1, 1'b0, 1'b0, 2'h0));
      cyc(20);
      `CHK(o_count_value, 16'h0000)
      i_start_trig <= (t != 2);
      cyc(20);
      `CHK(o_count_value > 16'h000A, 1'b1)
    end
    apb(1'b1, `TBC_OFS_CTRL, ctl(2'h0, 2'h0, 1'b1, 1'b0, 1'b0, 2'h3));
    cyc(2);
    c0 = o_count_value;
    cyc(80);
    d = o_count_value - c0;
    `CHK(d >= 16'h9 && d <= 16'hB, 1'b1)
    apb(1'b1, `TBC_OFS_CTRL, ctl(2'h0, 2'h0, 1'b1, 1'b0, 1'b1, 2'h0));
    cyc(2);
    c0 = o_count_value;
    repeat (40) begin
      cyc(4);
      i_ext_clk <= ~i_ext_clk;
    end
    cyc(4);
    d = o_count_value - c0;
    `CHK(d, 16'h0014)
    c0 = o_count_value;
    cyc(20);
    `CHK(o_count_value, c0)
    per = 16'h000C;
    apb(1'b1, `TBC_OFS_PERIOD, {16'h0, per});
    apb(1'b1, `TBC_OFS_STAT, 32'h3);
    apb(1'b1, `TBC_OFS_CTRL, ctl(2'h1, 2'h0, 1'b1, 1'b0, 1'b0, 2'h0));
    cyc(2);
    c0 = o_count_value;
    sp = 1'b0;
    sz = 1'b0;
    repeat (90) begin
      @(posedge i_sys_clk);
      d = o_count_value - c0;
      `CHK((d <= 16'h1 || d == 16'hFFFF) && o_count_value <= per, 1'b1)
      if (o_count_value === per) sp = 1'b1;
      if (sp && o_count_value === 16'h0000) sz = 1'b1;
      c0 = o_count_value;
    end
    `CHK({sp, sz}, 2'b11)
    apb(1'b0, `TBC_OFS_STAT, 32'h0);
    `CHK(rd[0], 1'b1)
    wrap_up();
  end
endmodule

`undef CHK
`default_nettype wire
